// ---- pario_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none

module pario_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clr,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (clr) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule : pario_fifo

`default_nettype wire

// ---- pario_periph_model.sv ----
// Peripheral taking output words by a flag handshake.
`timescale 1ns/1ns
`default_nettype none

module pario_periph_model (
    // Clock.
    input  wire logic        ref_clk,
    // Lines from the interface.
    input  wire logic [15:0] output_data_lines,
    input  wire logic        output_word_valid,
    input  wire logic        peripheral_control_line,
    // Pacing from the bench and handshake back.
    input  wire logic        stall,
    input  wire logic [3:0]  delay,
    output logic             peripheral_flag_line
);
    logic [15:0] got[$];

    // Flag answers a set control line and drops once it clears.
    initial begin
        peripheral_flag_line = 1'b0;
        forever begin
            @(posedge ref_clk) #1;
            if (peripheral_control_line && output_word_valid && !stall) begin
                repeat (delay) @(posedge ref_clk);
                #1;
                got.push_back(output_data_lines);
                peripheral_flag_line = 1'b1;
                while (peripheral_control_line) begin
                    @(posedge ref_clk) #1;
                end
                peripheral_flag_line = 1'b0;
            end
        end
    end
endmodule : pario_periph_model

`default_nettype wire

// ---- pario_pkg.sv ----
// Constants and types of the parallel I/O register map.
//
// Notes on behaviour
// RQ1 - Register 0 reads one when ready, else zero.
// RQ2 - Register 1 always reads the card identification.
// RQ3 - Register 3 reports interrupt, priority and DMA state.
// RQ4 - Registers 4 and 5 read input data high, low.
// RQ5 - Register 7 reports peripheral and inverted line states.
// RQ6 - Read 2, read 6, write 6 do nothing.
// RQ7 - Non-zero write 0 sets control line; zero ignored.
// RQ8 - Non-zero write 1 resets the whole interface; the two control outputs keep their values.
// RQ9 - Write 2 holds ready and external interrupt mask.
// RQ10 - Write 3 holds interrupt and DMA enables.
// RQ11 - Writes 4 and 5 load the output data.
// RQ12 - Write 7 sets the two control outputs.
// RQ13 - Software prefers the higher-level view over these.
// RQ14 - Bit 6 drives output one, bit 5 zero; low-true.
// RQ15 - Peripheral drives its status line; device only samples.
// RQ16 - Request raised by enabled masked-in active source.
`default_nettype none

package pario_pkg;

    localparam int DATA_WIDTH = 16;
    localparam int FIFO_DEPTH = 4;

    // Register offsets on the direct register port.
    localparam logic [2:0] ADDR_READY       = 3'h0;
    localparam logic [2:0] ADDR_CTRL_SET    = 3'h0;
    localparam logic [2:0] ADDR_CARD_ID     = 3'h1;
    localparam logic [2:0] ADDR_IFC_RESET   = 3'h1;
    localparam logic [2:0] ADDR_INTR_MASK   = 3'h2;
    localparam logic [2:0] ADDR_INTR_DMA    = 3'h3;
    localparam logic [2:0] ADDR_DATA_HIGH   = 3'h4;
    localparam logic [2:0] ADDR_DATA_LOW    = 3'h5;
    localparam logic [2:0] ADDR_LINES       = 3'h7;

    // Interrupt and DMA fields.
    localparam int BIT_INTR_EN   = 7;
    localparam int BIT_INTR_REQ  = 6;
    localparam int BIT_LEVEL_LO  = 4;
    localparam int BIT_BURST_DMA = 3;
    localparam int BIT_WORD_DMA  = 2;
    localparam int BIT_DMA_ONE   = 1;
    localparam int BIT_DMA_ZERO  = 0;

    // Interrupt mask fields.
    localparam int BIT_MASK_READY = 1;
    localparam int BIT_MASK_EXT   = 0;

    // Control output fields.
    localparam int BIT_CTL_ONE  = 6;
    localparam int BIT_CTL_ZERO = 5;

    // Peripheral line status fields.
    localparam int BIT_PERIPH_OK = 3;
    localparam int BIT_EXT_LOW   = 2;
    localparam int BIT_STAT1_LOW = 1;
    localparam int BIT_STAT0_LOW = 0;

    // Values after reset.
    localparam logic [1:0]  RST_MASK     = 2'h0;
    localparam logic [4:0]  RST_ENABLES  = 5'h00;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic        RST_CTL_LINE = 1'b1;

    typedef enum logic {OUT_IDLE, OUT_HOLD} out_state_t;

endpackage : pario_pkg

`default_nettype wire

// ---- pario_regs.sv ----
// Parallel I/O interface: direct register port, line sampling and buffered output path.
`timescale 1ns/1ns
`default_nettype none

module pario_regs #(
    // Identification code; this value is arbitrary.
    parameter logic [7:0] CARD_ID    = 8'h5a,
    parameter int         FIFO_DEPTH = pario_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                            ref_clk,
    input  wire logic                            nrst,
    // Direct register port.
    input  wire logic [2:0]                      reg_addr,
    input  wire logic                            reg_rd_en,
    input  wire logic                            reg_wr_en,
    input  wire logic [7:0]                      reg_wdata,
    output logic [7:0]                           reg_rdata,
    output logic                                 reg_rd_valid,
    // Lines from the peripheral.
    input  wire logic [pario_pkg::DATA_WIDTH-1:0] input_data_lines,
    input  wire logic                            peripheral_ok_line,
    input  wire logic                            external_interrupt_line,
    input  wire logic                            status_input_zero,
    input  wire logic                            status_input_one,
    input  wire logic                            peripheral_flag_line,
    input  wire logic [1:0]                      level_switches,
    // Lines to the peripheral.
    output logic [pario_pkg::DATA_WIDTH-1:0]     output_data_lines,
    output logic                                 output_word_valid,
    output logic                                 peripheral_control_line,
    output logic                                 control_output_zero,
    output logic                                 control_output_one,
    // Status toward the host.
    output logic                                 interrupt_request,
    output logic [3:0]                           dma_enables
);
    import pario_pkg::*;

    localparam int SYNC_W = DATA_WIDTH + 7;

    // Reset release.
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Two-stage sampling of every peripheral pin.
    logic [SYNC_W-1:0] pins_meta_ff;
    logic [SYNC_W-1:0] pins_sync_ff;
    logic [DATA_WIDTH-1:0] data_in_s;
    logic              ok_s;
    logic              ext_s;
    logic              stat0_s;
    logic              stat1_s;
    logic              flag_s;
    logic [1:0]        level_s;
    logic              flag_prev_ff;
    logic              flag_rise;

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pins_meta_ff <= '0;
            pins_sync_ff <= '0;
        end else begin
            pins_meta_ff <= {input_data_lines, peripheral_ok_line, external_interrupt_line,
                             status_input_zero, status_input_one, peripheral_flag_line,
                             level_switches};
            pins_sync_ff <= pins_meta_ff;
        end
    end

    // Sampled values are live, never latched. RQ15
    assign {data_in_s, ok_s, ext_s, stat0_s, stat1_s, flag_s, level_s} = pins_sync_ff;

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            flag_prev_ff <= 1'b0;
        end else begin
            flag_prev_ff <= flag_s;
        end
    end

    assign flag_rise = flag_s && !flag_prev_ff;

    // Write decode.
    logic wr_ctrl_set;
    logic wr_ifc_reset;
    logic wr_mask;
    logic wr_enables;
    logic wr_high;
    logic wr_low;
    logic wr_lines;
    logic nonzero;

    assign nonzero      = (reg_wdata != 8'h00);
    assign wr_ctrl_set  = reg_wr_en && (reg_addr == ADDR_CTRL_SET) && nonzero;  // RQ7
    assign wr_ifc_reset = reg_wr_en && (reg_addr == ADDR_IFC_RESET) && nonzero; // RQ8
    assign wr_mask      = reg_wr_en && (reg_addr == ADDR_INTR_MASK);
    assign wr_enables   = reg_wr_en && (reg_addr == ADDR_INTR_DMA);
    assign wr_high      = reg_wr_en && (reg_addr == ADDR_DATA_HIGH);
    assign wr_low       = reg_wr_en && (reg_addr == ADDR_DATA_LOW);
    assign wr_lines     = reg_wr_en && (reg_addr == ADDR_LINES);

    // Interface reset pulse.
    logic soft_rst_ff;

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_ifc_reset; // RQ8
        end
    end

    // Interrupt mask and enables.
    logic [1:0] mask_ff;
    logic [4:0] enables_ff;

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            mask_ff <= RST_MASK;
        end else if (soft_rst_ff) begin
            mask_ff <= RST_MASK;
        end else if (wr_mask) begin
            mask_ff <= {reg_wdata[BIT_MASK_READY], reg_wdata[BIT_MASK_EXT]}; // RQ9
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            enables_ff <= RST_ENABLES;
        end else if (soft_rst_ff) begin
            enables_ff <= RST_ENABLES;
        end else if (wr_enables) begin
            enables_ff <= {reg_wdata[BIT_INTR_EN], reg_wdata[BIT_BURST_DMA:BIT_DMA_ZERO]}; // RQ10
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            dma_enables <= RST_ENABLES[3:0];
        end else begin
            dma_enables <= enables_ff[3:0]; // RQ10
        end
    end

    // The high byte is staged; a low-byte write pushes the word.
    logic [7:0]            out_high_ff;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic                  fifo_out_ready;
    logic [DATA_WIDTH-1:0] fifo_out_data;
    out_state_t            out_state_ff;

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            out_high_ff <= RST_BYTE;
        end else if (soft_rst_ff) begin
            out_high_ff <= RST_BYTE;
        end else if (wr_high) begin
            out_high_ff <= reg_wdata; // RQ11
        end
    end

    pario_fifo #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_out_fifo (
        .clk       (ref_clk),
        .rst_n     (rst_sync_ff),
        .clr       (soft_rst_ff),
        .in_valid  (wr_low),
        .in_ready  (fifo_in_ready),
        .in_data   ({out_high_ff, reg_wdata}), // RQ11
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = (out_state_ff == OUT_IDLE) && !soft_rst_ff;

    // A peripheral acknowledge retires the held word.
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            out_state_ff <= OUT_IDLE;
        end else if (soft_rst_ff) begin
            out_state_ff <= OUT_IDLE;
        end else begin
            unique case (out_state_ff)
                OUT_IDLE: begin
                    if (fifo_out_valid) begin
                        out_state_ff <= OUT_HOLD;
                    end
                end
                OUT_HOLD: begin
                    if (flag_rise && peripheral_control_line) begin
                        out_state_ff <= OUT_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            output_data_lines <= RST_WORD;
        end else if (soft_rst_ff) begin
            output_data_lines <= RST_WORD;
        end else if (fifo_out_valid && fifo_out_ready) begin
            output_data_lines <= fifo_out_data; // RQ11
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            output_word_valid <= 1'b0;
        end else if (soft_rst_ff) begin
            output_word_valid <= 1'b0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            output_word_valid <= 1'b1;
        end else if (flag_rise && peripheral_control_line) begin
            output_word_valid <= 1'b0;
        end
    end

    // Control line: a set write wins over a same-cycle acknowledge.
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            peripheral_control_line <= 1'b0;
        end else if (wr_ctrl_set) begin
            peripheral_control_line <= 1'b1; // RQ7
        end else if (soft_rst_ff || flag_rise) begin
            peripheral_control_line <= 1'b0;
        end
    end

    // Control outputs are low-true and survive the interface reset.
    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            control_output_zero <= RST_CTL_LINE;
            control_output_one  <= RST_CTL_LINE;
        end else if (wr_lines) begin
            control_output_zero <= !reg_wdata[BIT_CTL_ZERO]; // RQ12 RQ14
            control_output_one  <= !reg_wdata[BIT_CTL_ONE];  // RQ12 RQ14
        end
    end

    // Ready means the buffer can take another word.
    logic ready_s;

    assign ready_s = fifo_in_ready && !soft_rst_ff; // RQ1

    // Interrupt request.
    logic nxt_intr;

    assign nxt_intr = enables_ff[4] &&
                      ((mask_ff[1] && ready_s) || (mask_ff[0] && !ext_s)); // RQ16

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            interrupt_request <= 1'b0;
        end else begin
            interrupt_request <= nxt_intr; // RQ16
        end
    end

    // Read data, one cycle after the read strobe.
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00; // RQ6
        unique case (reg_addr)
            ADDR_READY: begin
                nxt_rdata = {7'h00, ready_s}; // RQ1
            end
            ADDR_CARD_ID: begin
                nxt_rdata = CARD_ID; // RQ2
            end
            ADDR_INTR_DMA: begin
                nxt_rdata[BIT_INTR_EN]                  = enables_ff[4];     // RQ3
                nxt_rdata[BIT_INTR_REQ]                 = interrupt_request; // RQ3
                nxt_rdata[BIT_LEVEL_LO+1:BIT_LEVEL_LO]  = level_s;           // RQ3
                nxt_rdata[BIT_BURST_DMA:BIT_DMA_ZERO]   = enables_ff[3:0];   // RQ3
            end
            ADDR_DATA_HIGH: begin
                nxt_rdata = data_in_s[15:8]; // RQ4
            end
            ADDR_DATA_LOW: begin
                nxt_rdata = data_in_s[7:0]; // RQ4
            end
            ADDR_LINES: begin
                nxt_rdata[BIT_PERIPH_OK] = ok_s;    // RQ5
                nxt_rdata[BIT_EXT_LOW]   = !ext_s;  // RQ5
                nxt_rdata[BIT_STAT1_LOW] = !stat1_s; // RQ5
                nxt_rdata[BIT_STAT0_LOW] = !stat0_s; // RQ5
            end
            default: begin
                nxt_rdata = 8'h00; // RQ6
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

endmodule : pario_regs

`default_nettype wire

// ---- pario_regs_checker.sv ----
// Assertions on the parallel I/O register port and lines.
`timescale 1ns/1ns
`default_nettype none

module pario_regs_checker #(
    parameter logic [7:0] CARD_ID = 8'h5a // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Register port.
    input  wire logic [2:0] reg_addr,
    input  wire logic       reg_rd_en,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid,
    // Lines and status.
    input  wire logic       peripheral_control_line,
    input  wire logic       control_output_zero,
    input  wire logic       control_output_one,
    input  wire logic       output_word_valid,
    input  wire logic [3:0] dma_enables
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic set_req;
    logic ctl_req;

    assign set_req = reg_wr_en && reg_addr == 3'h0 && |reg_wdata;
    assign ctl_req = reg_wr_en && reg_addr == 3'h7;

    AST_RD_PULSE: assert property (reg_rd_valid == $past(reg_rd_en))
        else $error("read valid late");
    AST_RDATA_HOLD: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved");
    AST_CARD_ID: assert property (reg_rd_en && reg_addr == 3'h1 |=> reg_rdata == CARD_ID)
        else $error("card id wrong");
    AST_UNDEF_READ: assert property (reg_rd_en && reg_addr inside {3'h2, 3'h6}
        |=> reg_rdata == 8'h00) else $error("undefined not zero");
    AST_LINES_TOP: assert property (reg_rd_en && reg_addr == 3'h7
        |=> reg_rdata[7:4] == 4'h0) else $error("line bits 7-4 set");
    AST_CTRL_SET: assert property (set_req |=> peripheral_control_line)
        else $error("control line not set");
    AST_CTRL_CAUSE: assert property ($rose(peripheral_control_line) |-> $past(set_req))
        else $error("stray control line set");
    AST_CTL_WRITE: assert property (ctl_req |=>
        {control_output_one, control_output_zero} == ~$past(reg_wdata[6:5]))
        else $error("outputs miss write");
    AST_CTL_HOLD: assert property (!ctl_req |=>
        $stable({control_output_one, control_output_zero}))
        else $error("outputs moved");
    AST_DMA_LOAD: assert property (reg_wr_en && reg_addr == 3'h3
        |-> ##2 dma_enables == $past(reg_wdata[3:0], 2)) else $error("enables not loaded");
    AST_IFC_RESET: assert property (reg_wr_en && reg_addr == 3'h1 && |reg_wdata
        |-> ##3 (dma_enables == 4'h0 && !peripheral_control_line && !output_word_valid))
        else $error("reset left state");
endmodule : pario_regs_checker

bind pario_regs pario_regs_checker #(.CARD_ID(CARD_ID)) pario_regs_checker_inst (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .peripheral_control_line(peripheral_control_line),
    .control_output_zero(control_output_zero), .control_output_one(control_output_one),
    .output_word_valid(output_word_valid), .dma_enables(dma_enables));

`default_nettype wire

// ---- pario_regs_tb_top.sv ----
// Self-checking bench for the parallel I/O register map.
`timescale 1ns/1ns
`default_nettype none

module pario_regs_tb_top;
    import pario_pkg::*;
    // Identification value; arbitrary.
    localparam logic [7:0] CARD_ID = 8'hc6;

    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic        reg_rd_en = 1'b0;
    logic        reg_wr_en = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        reg_rd_valid;
    logic [15:0] input_data_lines = 16'h0000;
    logic        peripheral_ok_line = 1'b1;
    logic        external_interrupt_line = 1'b1;
    logic        status_input_zero = 1'b1;
    logic        status_input_one = 1'b1;
    logic        peripheral_flag_line;
    logic [1:0]  level_switches = 2'h0;
    logic [15:0] output_data_lines;
    logic        output_word_valid;
    logic        peripheral_control_line;
    logic        control_output_zero;
    logic        control_output_one;
    logic        interrupt_request;
    logic [3:0]  dma_enables;
    logic        stall = 1'b0;
    logic [3:0]  delay = 4'h0;
    int          failures = 0;
    int          cmp_count = 0;
    logic [15:0] exp_q[$];
    logic [15:0] w;
    logic [7:0]  e;
    logic [3:0]  p;
    logic        x;
    int          n;

    always #10 ref_clk = ~ref_clk;

    pario_regs #(.CARD_ID(CARD_ID), .FIFO_DEPTH(FIFO_DEPTH)) pario_regs_inst (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .input_data_lines(input_data_lines),
        .peripheral_ok_line(peripheral_ok_line),
        .external_interrupt_line(external_interrupt_line),
        .status_input_zero(status_input_zero), .status_input_one(status_input_one),
        .peripheral_flag_line(peripheral_flag_line), .level_switches(level_switches),
        .output_data_lines(output_data_lines), .output_word_valid(output_word_valid),
        .peripheral_control_line(peripheral_control_line),
        .control_output_zero(control_output_zero), .control_output_one(control_output_one),
        .interrupt_request(interrupt_request), .dma_enables(dma_enables));

    pario_periph_model pario_periph_model_inst (
        .ref_clk(ref_clk), .output_data_lines(output_data_lines),
        .output_word_valid(output_word_valid),
        .peripheral_control_line(peripheral_control_line), .stall(stall), .delay(delay),
        .peripheral_flag_line(peripheral_flag_line));

    function automatic logic [7:0] exp_lines(input logic [3:0] v);
        return {4'h0, v[3], ~v[2:0]};
    endfunction : exp_lines

    function automatic logic exp_intr(input logic en, input logic [1:0] m, input logic ext);
        return en & (m[1] | (m[0] & ~ext));
    endfunction : exp_intr

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr_en = 1'b0;
    endtask : wr

    task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk) #1;
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge ref_clk) #1;
        reg_rd_en = 1'b0;
        chk(what, reg_rdata, exp);
    endtask : rd_chk

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run

    initial begin
        #400000;
        failures++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h60b9ad9f));
        repeat (4) @(posedge ref_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge ref_clk);
        rd_chk("card id", ADDR_CARD_ID, CARD_ID);
        rd_chk("undefined 2", 3'h2, 8'h00);
        rd_chk("undefined 6", 3'h6, 8'h00);
        wr(3'h6, 8'hff);
        rd_chk("ready", ADDR_READY, 8'h01);
        $display("test fixed places done");
        for (int i = 0; i < 8; i++) begin
            p = (i < 2) ? {4{i[0]}} : 4'($urandom);
            {peripheral_ok_line, external_interrupt_line, status_input_one} = p[3:1];
            status_input_zero = p[0];
            w = 16'($urandom);
            input_data_lines = w;
            repeat (4) @(posedge ref_clk);
            rd_chk("lines", ADDR_LINES, exp_lines(p));
            rd_chk("data high", ADDR_DATA_HIGH, w[15:8]);
            rd_chk("data low", ADDR_DATA_LOW, w[7:0]);
        end
        $display("test line reads done");
        for (int i = 0; i < 6; i++) begin
            external_interrupt_line = ~i[0];
            level_switches = 2'($urandom);
            e = 8'($urandom);
            e[7] = (i < 4);
            wr(ADDR_INTR_MASK, {6'($urandom), i[1:0]});
            wr(ADDR_INTR_DMA, e);
            repeat (4) @(posedge ref_clk) #1;
            x = exp_intr(e[7], i[1:0], external_interrupt_line);
            chk("request", interrupt_request, x);
            rd_chk("intr dma", ADDR_INTR_DMA, {e[7], x, level_switches, e[3:0]});
            chk("dma", dma_enables, e[3:0]);
        end
        $display("test interrupt and dma done");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_LINES, {1'($urandom), i[1:0], 5'($urandom)});
            chk("ctl one", control_output_one, !i[1]);
            chk("ctl zero", control_output_zero, !i[0]);
        end
        $display("test control outputs done");
        stall = 1'b1;
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 16'hffff : 16'($urandom);
            if (i < 5) exp_q.push_back(w);
            rd_chk("ready fill", ADDR_READY, 8'(i < 5));
            wr(ADDR_DATA_HIGH, w[15:8]);
            wr(ADDR_DATA_LOW, w[7:0]);
        end
        stall = 1'b0;
        wr(ADDR_CTRL_SET, 8'h00);
        chk("zero set write", peripheral_control_line, 1'b0);
        for (int i = 0; i < 5; i++) begin
            delay = 4'($urandom);
            wr(ADDR_CTRL_SET, (i == 0) ? 8'h01 : (8'($urandom) | 8'h80));
            for (n = 0; peripheral_control_line && n < 80; n++) @(posedge ref_clk) #1;
            chk("ack wait", n < 80, 1'b1);
            repeat (3) @(posedge ref_clk);
        end
        chk("word count", 16'(pario_periph_model_inst.got.size()), 16'h0005);
        foreach (exp_q[i]) chk("word", pario_periph_model_inst.got[i], exp_q[i]);
        rd_chk("ready drained", ADDR_READY, 8'h01);
        $display("test buffered output done");
        stall = 1'b1;
        wr(ADDR_INTR_DMA, 8'h8f);
        wr(ADDR_INTR_MASK, 8'h02);
        wr(ADDR_DATA_LOW, 8'h3c);
        wr(ADDR_CTRL_SET, 8'h01);
        wr(ADDR_IFC_RESET, 8'h00);
        repeat (4) @(posedge ref_clk) #1;
        chk("dma kept", dma_enables, 4'hf);
        chk("request before", interrupt_request, 1'b1);
        wr(ADDR_IFC_RESET, 8'($urandom) | 8'h10);
        repeat (4) @(posedge ref_clk) #1;
        chk("dma cleared", dma_enables, 4'h0);
        chk("control cleared", peripheral_control_line, 1'b0);
        chk("word cleared", output_word_valid, 1'b0);
        chk("request cleared", interrupt_request, 1'b0);
        chk("ctl one kept", control_output_one, 1'b0);
        rd_chk("intr dma cleared", ADDR_INTR_DMA, {2'b00, level_switches, 4'h0});
        stall = 1'b0;
        $display("test interface reset done");
        complete_run();
    end
endmodule : pario_regs_tb_top

`default_nettype wire
